// ---- rtl/mdsu_pkg.sv ----
// ==========================================================================
// shared constants and types of the multiply, divide and shift unit
// ==========================================================================
package mdsu_pkg;

    // ======================================================================
    // register map, byte addresses on the special function bus
    // ======================================================================
    localparam logic [7:0] ADDR_OPERAND_0     = 8'hE9;
    localparam logic [7:0] ADDR_OPERAND_1     = 8'hEA;
    localparam logic [7:0] ADDR_OPERAND_2     = 8'hEB;
    localparam logic [7:0] ADDR_OPERAND_3     = 8'hEC;
    localparam logic [7:0] ADDR_OPERAND_4     = 8'hED;
    localparam logic [7:0] ADDR_OPERAND_5     = 8'hEE;
    localparam logic [7:0] ADDR_ARITH_CONTROL = 8'hEF;

    // ======================================================================
    // arith_control field positions and reset values
    // ======================================================================
    localparam int         CTRL_ERR_BIT    = 7;
    localparam int         CTRL_OVF_BIT    = 6;
    localparam int         CTRL_DIR_BIT    = 5;
    localparam int         CTRL_CNT_LSB    = 0;
    localparam int         CTRL_CNT_WIDTH  = 5;
    localparam logic [7:0] CTRL_RESET      = 8'h00;
    localparam logic [7:0] OPERAND_RESET   = 8'h00;
    localparam logic [7:0] UNMAPPED_READ   = 8'h00;

    // ======================================================================
    // timing: one machine cycle, expressed in reference clock cycles
    // ======================================================================
    localparam int CLK_PERIOD_NS     = 10;
    localparam int MCYCLE_NS         = 1000;
    localparam int MCYCLE_CLKS       = (MCYCLE_NS + CLK_PERIOD_NS - 1)
                                       / CLK_PERIOD_NS;
    localparam int DIV32_MCYCLES     = 6;
    localparam int DIV16_MCYCLES     = 4;
    localparam int MUL_MCYCLES       = 4;
    localparam int SHIFTS_PER_MCYCLE = 6;
    localparam int BUSY_CNT_WIDTH    = 10;

    // ======================================================================
    // operations and carriers
    // ======================================================================
    typedef enum {
        MDSU_OP_DIV32,
        MDSU_OP_DIV16,
        MDSU_OP_MUL,
        MDSU_OP_SHIFT,
        MDSU_OP_NORM
    } mdsu_op_t;

    // register bus request from the cpu core
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } mdsu_bus_t;

    // outcome of one operation, computed from the operand bytes
    typedef struct packed {
        logic [47:0] bytes;
        logic        overflow;
        logic [4:0]  count;
        logic [2:0]  mcycles;
    } mdsu_result_t;

endpackage

// ---- rtl/mdsu_calc.sv ----
`timescale 1ns/1ps
// ==========================================================================
// combinational arithmetic core: results, flags and run length
// ==========================================================================
module mdsu_calc
    import mdsu_pkg::*;
(
    input  var  mdsu_pkg::mdsu_op_t op,
    input  wire logic [47:0]        operands,
    input  wire logic               shift_dir,
    input  wire logic [4:0]         shift_cnt,
    output mdsu_pkg::mdsu_result_t  result
);

    // ======================================================================
    // operand views
    // ======================================================================
    wire [31:0] value32   = operands[31:0];
    wire [15:0] divisor   = operands[47:32];
    wire [15:0] low16     = operands[15:0];
    wire        div_zero  = (divisor == 16'h0000);
    wire [31:0] safe_div  = div_zero ? 32'h0000_0001 : {16'h0000, divisor};
    wire [31:0] quo32     = value32 / safe_div;
    wire [31:0] rem32     = value32 % safe_div;
    wire [31:0] quo16     = {16'h0000, low16} / safe_div;
    wire [31:0] rem16     = {16'h0000, low16} % safe_div;
    wire [31:0] product   = low16 * divisor;
    wire [31:0] shl_value = value32 << shift_cnt;
    wire [31:0] shr_value = value32 >> shift_cnt;
    wire [4:0]  lead_zero = lead_zeros(value32);
    wire [31:0] norm_val  = value32 << lead_zero;

    // leading zeros of a nonzero word; a zero word needs no shifting
    function automatic logic [4:0] lead_zeros(input logic [31:0] v);
        logic [4:0] n;
        logic       found;
        n     = 5'h00;
        found = 1'b0;
        for (int i = 31; i >= 0; i--)
        begin
            if (!found && v[i])
            begin
                found = 1'b1;
                n     = 5'(31 - i);
            end
        end
        return n;
    endfunction

    // machine cycles for a shift run, six positions each, at least one
    function automatic logic [2:0] shift_mcycles(input logic [4:0] n);
        logic [5:0] t;
        t = ({1'b0, n} + 6'(SHIFTS_PER_MCYCLE - 1)) / 6'(SHIFTS_PER_MCYCLE);
        return (t == 6'h00) ? 3'h1 : t[2:0];
    endfunction

    // ======================================================================
    // result selection; a zero divisor leaves the operands in place
    // ======================================================================
    always_comb
    begin
        result.bytes    = operands;
        result.overflow = 1'b0;
        result.count    = shift_cnt;
        result.mcycles  = 3'h1;
        unique case (op)
            MDSU_OP_DIV32:
            begin
                result.overflow = div_zero;
                result.mcycles  = 3'(DIV32_MCYCLES);
                if (!div_zero)
                    result.bytes = {rem32[15:0], quo32};
            end
            MDSU_OP_DIV16:
            begin
                result.overflow = div_zero;
                result.mcycles  = 3'(DIV16_MCYCLES);
                if (!div_zero)
                    result.bytes = {rem16[15:0], operands[31:16],
                                    quo16[15:0]};
            end
            MDSU_OP_MUL:
            begin
                result.overflow = (product[31:16] != 16'h0000);
                result.mcycles  = 3'(MUL_MCYCLES);
                result.bytes    = {operands[47:32], product};
            end
            MDSU_OP_SHIFT:
            begin
                result.mcycles = shift_mcycles(shift_cnt);
                result.bytes   = {operands[47:32],
                                  shift_dir ? shr_value : shl_value};
            end
            MDSU_OP_NORM:
            begin
                result.overflow = value32[31];
                result.count    = lead_zero;
                result.mcycles  = shift_mcycles(lead_zero);
                result.bytes    = {operands[47:32], norm_val};
            end
        endcase
    end

endmodule // mdsu_calc

// ---- rtl/mdsu_unit.sv ----
// Added by the designer: strobed register access.
`timescale 1ns/1ps
// ==========================================================================
// multiply, divide, shift and normalize unit behind the register bus
// ==========================================================================
// Operation
// - writing operand byte 5 last starts the chosen multiply or divide
// - after completion the operand bytes hold result and remainder
// - writing arith_control starts a shift or normalize on bytes 0..3
// - an operand write while busy sets the retrigger error flag
// - overflow on divide by zero, big product, normalize with bit 31 set
// - the written overflow bit is ignored; every start loads the flag from its result
// - direction one shifts right, zero shifts left
// - zero count selects normalize; count then reports shifts taken
// - nonzero count shifts by exactly that many positions
// - least significant byte sits in the lowest register of a group
// - write order selects 32/16 divide, 16/16 divide or multiply
// - 32/16 quotient or product in bytes 0..3, 16/16 quotient in bytes 0..1, remainder in bytes 4..5
// - run lengths six, four, four, and shifts at six per cycle
module mdsu_unit
    import mdsu_pkg::*;
#(
    parameter int MCYCLE_CLOCKS = MCYCLE_CLKS
)
(
    input  wire logic                REF_CLK,
    input  wire logic                RESET_N,
    input  wire logic                CLK_EN,
    input  wire mdsu_pkg::mdsu_bus_t BUS_REQ,
    output logic [7:0]               BUS_RDATA,
    output logic                     BUSY
);

    // ======================================================================
    // write sequence tracking
    // ======================================================================
    typedef enum {
        SEQ_IDLE,
        SEQ_B0,
        SEQ_B01,
        SEQ_B012,
        SEQ_B0123,
        SEQ_B01234,
        SEQ_B014,
        SEQ_B04,
        SEQ_B041
    } mdsu_seq_t;

    mdsu_seq_t    seq_q;
    mdsu_seq_t    seq_d;
    logic [47:0]  operand_q;
    logic [7:0]   ctrl_q;
    logic [7:0]   rdata_q;
    logic         busy_q;
    logic [BUSY_CNT_WIDTH-1:0] busy_cnt_q;
    mdsu_op_t     op_q;
    mdsu_op_t     start_op;
    mdsu_op_t     calc_op;
    mdsu_result_t calc_res;

    // ======================================================================
    // address decode, shared by the write and read paths
    // ======================================================================
    function automatic logic [2:0] operand_index(input logic [7:0] a);
        return 3'(a - ADDR_OPERAND_0);
    endfunction

    function automatic logic is_operand(input logic [7:0] a);
        return (a >= ADDR_OPERAND_0) && (a <= ADDR_OPERAND_5);
    endfunction

    wire       wr_any     = BUS_REQ.wr;
    wire       wr_operand = wr_any && is_operand(BUS_REQ.addr);
    wire       wr_ctrl    = wr_any && (BUS_REQ.addr == ADDR_ARITH_CONTROL);
    wire       rd_ctrl    = BUS_REQ.rd
                            && (BUS_REQ.addr == ADDR_ARITH_CONTROL);
    wire       rd_operand = BUS_REQ.rd && is_operand(BUS_REQ.addr);
    wire [2:0] wr_index   = operand_index(BUS_REQ.addr);
    wire [2:0] rd_index   = operand_index(BUS_REQ.addr);

    // ======================================================================
    // start conditions
    // ======================================================================
    // writes while busy are refused, so operands stay stable for the run
    wire accept_wr  = wr_any && !busy_q;
    wire last_byte  = accept_wr && wr_operand && (wr_index == 3'h5);
    wire start_md   = last_byte && ((seq_q == SEQ_B01234)
                                    || (seq_q == SEQ_B014)
                                    || (seq_q == SEQ_B041));
    wire start_sh   = accept_wr && wr_ctrl;
    wire start_any  = start_md || start_sh;
    wire wr_is_norm = (BUS_REQ.wdata[CTRL_CNT_LSB +: CTRL_CNT_WIDTH]
                       == 5'h00);

    always_comb
    begin
        start_op = MDSU_OP_DIV32;
        if (start_sh)
            start_op = wr_is_norm ? MDSU_OP_NORM : MDSU_OP_SHIFT;
        else if (seq_q == SEQ_B014)
            start_op = MDSU_OP_DIV16;
        else if (seq_q == SEQ_B041)
            start_op = MDSU_OP_MUL;
    end

    // a started shift sees the freshly written direction and count
    wire [7:0] ctrl_view  = start_sh ? BUS_REQ.wdata : ctrl_q;
    assign     calc_op    = busy_q ? op_q : start_op;

    // ======================================================================
    // arithmetic core
    // ======================================================================
    // overflow sees final byte
    // the starting write lands at the same edge, so its byte is merged
    // here, or a divide or multiply would flag on a stale divisor
    wire [47:0] calc_in = last_byte ? {BUS_REQ.wdata, operand_q[39:0]}
                                    : operand_q;

    mdsu_calc u_calc (
        .op        (calc_op),
        .operands  (calc_in),
        .shift_dir (ctrl_view[CTRL_DIR_BIT]),
        .shift_cnt (ctrl_view[CTRL_CNT_LSB +: CTRL_CNT_WIDTH]),
        .result    (calc_res)
    );

    wire [BUSY_CNT_WIDTH-1:0] run_clocks =
        BUSY_CNT_WIDTH'(int'(calc_res.mcycles) * MCYCLE_CLOCKS - 1);
    wire finish = busy_q && (busy_cnt_q == '0);

    // ======================================================================
    // next write sequence state
    // ======================================================================
    // byte 0 opens a sequence from any state, unless written while busy
    always_comb
    begin
        seq_d = seq_q;
        if (wr_any && busy_q)
            seq_d = SEQ_IDLE;
        else if (start_any)
            seq_d = SEQ_IDLE;
        else if (accept_wr && wr_operand && wr_index == 3'h0)
            seq_d = SEQ_B0;
        else if (accept_wr && (wr_operand || wr_ctrl))
        begin
            seq_d = SEQ_IDLE;
            unique case (seq_q)
                SEQ_B0:
                    if (wr_index == 3'h1)
                        seq_d = SEQ_B01;
                    else if (wr_index == 3'h4)
                        seq_d = SEQ_B04;
                SEQ_B01:
                    if (wr_index == 3'h2)
                        seq_d = SEQ_B012;
                    else if (wr_index == 3'h4)
                        seq_d = SEQ_B014;
                SEQ_B012:
                    if (wr_index == 3'h3)
                        seq_d = SEQ_B0123;
                SEQ_B0123:
                    if (wr_index == 3'h4)
                        seq_d = SEQ_B01234;
                SEQ_B04:
                    if (wr_index == 3'h1)
                        seq_d = SEQ_B041;
                SEQ_IDLE, SEQ_B01234, SEQ_B014, SEQ_B041:
                    seq_d = SEQ_IDLE;
            endcase
        end
    end

    always_ff @(posedge REF_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            seq_q <= SEQ_IDLE;
        else if (CLK_EN)
            seq_q <= seq_d;
    end

    // ======================================================================
    // operand bytes, one per register, least significant lowest
    // ======================================================================
    genvar g;
    generate
        for (g = 0; g < 6; g++)
        begin : g_operand
            wire byte_wr = accept_wr && wr_operand
                           && (wr_index == 3'(g));
            always_ff @(posedge REF_CLK or negedge RESET_N)
            begin
                if (!RESET_N)
                    operand_q[8*g +: 8] <= OPERAND_RESET;
                else if (CLK_EN)
                begin
                    if (finish)
                        operand_q[8*g +: 8] <= calc_res.bytes[8*g +: 8];
                    else if (byte_wr)
                        operand_q[8*g +: 8] <= BUS_REQ.wdata;
                end
            end
        end
    endgenerate

    // ======================================================================
    // run control: busy flag, clock countdown and latched operation
    // ======================================================================
    // timed run
    always_ff @(posedge REF_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            busy_q     <= 1'b0;
            busy_cnt_q <= '0;
            op_q       <= MDSU_OP_DIV32;
        end
        else if (CLK_EN)
        begin
            if (start_any)
            begin
                busy_q     <= 1'b1;
                busy_cnt_q <= run_clocks;
                op_q       <= start_op;
            end
            else if (finish)
                busy_q <= 1'b0;
            else if (busy_q)
                busy_cnt_q <= busy_cnt_q - 1'b1;
        end
    end

    // ======================================================================
    // arith_control fields
    // ======================================================================
    // retrigger by operand write
    wire err_set   = wr_operand && busy_q;
    wire err_next  = err_set || (ctrl_q[CTRL_ERR_BIT] && !rd_ctrl);
    wire ovf_next  = start_any ? calc_res.overflow : ctrl_q[CTRL_OVF_BIT];
    wire dir_next  = start_sh ? BUS_REQ.wdata[CTRL_DIR_BIT]
                              : ctrl_q[CTRL_DIR_BIT];
    wire [4:0] cnt_next =
        start_sh ? BUS_REQ.wdata[CTRL_CNT_LSB +: CTRL_CNT_WIDTH]
      : (finish && op_q == MDSU_OP_NORM) ? calc_res.count
      : ctrl_q[CTRL_CNT_LSB +: CTRL_CNT_WIDTH];

    always_ff @(posedge REF_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            ctrl_q <= CTRL_RESET;
        else if (CLK_EN)
            ctrl_q <= {err_next, ovf_next, dir_next, cnt_next};
    end

    // ======================================================================
    // read path, answer one cycle after the strobe
    // ======================================================================
    // results may be read while busy but show the old operand bytes
    wire [7:0] rd_mux = rd_ctrl    ? ctrl_q
                      : rd_operand ? operand_q[8*rd_index +: 8]
                      : UNMAPPED_READ;

    always_ff @(posedge REF_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            rdata_q <= UNMAPPED_READ;
        else if (CLK_EN)
            rdata_q <= BUS_REQ.rd ? rd_mux : UNMAPPED_READ;
    end

    assign BUS_RDATA = rdata_q;
    assign BUSY      = busy_q;

endmodule // mdsu_unit

// ---- test/mdsu_unit_checker.sv ----
`timescale 1ns/1ps
// ==========================================================
// port assertions for the arithmetic unit
// ==========================================================
module mdsu_unit_checker
    import mdsu_pkg::*;
#(
    parameter int MCYCLE_CLOCKS = MCYCLE_CLKS
)
(
    input wire logic                REF_CLK,
    input wire logic                RESET_N,
    input wire logic                CLK_EN,
    input wire mdsu_pkg::mdsu_bus_t BUS_REQ,
    input wire logic [7:0]          BUS_RDATA,
    input wire logic                BUSY
);
    // longest run is six machine cycles
    localparam int MAX_RUN = 6 * MCYCLE_CLOCKS;
    logic [15:0] run_q;
    wire         ctl_wr;
    wire         ctl_rd;
    wire         op_wr;
    wire         start_wr;

    // strobe decode; the enable gates every request
    assign ctl_wr = CLK_EN && BUS_REQ.wr && BUS_REQ.addr == ADDR_ARITH_CONTROL;
    assign ctl_rd = CLK_EN && BUS_REQ.rd && BUS_REQ.addr == ADDR_ARITH_CONTROL;
    assign op_wr  = CLK_EN && BUS_REQ.wr && BUS_REQ.addr >= ADDR_OPERAND_0
                    && BUS_REQ.addr <= ADDR_OPERAND_5;
    assign start_wr = ctl_wr || (op_wr && BUS_REQ.addr == ADDR_OPERAND_5);

    // busy length, read out when busy falls
    always_ff @(posedge REF_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            run_q <= 16'h0000;
        else if (CLK_EN)
            run_q <= BUSY ? run_q + 16'h0001 : 16'h0000;
    end

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESET_N);

    function automatic logic wr_at(mdsu_bus_t q, logic [7:0] a);
        return q.wr && q.addr == a;
    endfunction

    // multiply load, bytes 0, 4, 1, 5 back to back
    sequence mul_load;
        !BUSY && wr_at(BUS_REQ, ADDR_OPERAND_0)
        ##1 wr_at(BUS_REQ, ADDR_OPERAND_4)
        ##1 wr_at(BUS_REQ, ADDR_OPERAND_1)
        ##1 wr_at(BUS_REQ, ADDR_OPERAND_5);
    endsequence

    start_cause_a: assert property ($rose(BUSY) |->
        $past(start_wr))
        else $error("busy rose without a starting write");
    ctl_start_a: assert property (ctl_wr && !BUSY |=> BUSY)
        else $error("control write did not start a shift");
    mul_start_a: assert property (mul_load |=> BUSY)
        else $error("multiply load did not start");
    run_step_a: assert property ($fell(BUSY) |->
        run_q != 0 && run_q % MCYCLE_CLOCKS == 0)
        else $error("run is not whole machine cycles");
    run_bound_a: assert property ($rose(BUSY) |-> ##[1:MAX_RUN] !BUSY)
        else $error("run longer than six machine cycles");
    err_set_a: assert property (BUSY && op_wr ##1 ctl_rd |=>
        BUS_RDATA[CTRL_ERR_BIT]) else $error("retrigger left no error");
    err_clear_a: assert property (ctl_rd ##1 !op_wr ##1 ctl_rd |=>
        !BUS_RDATA[CTRL_ERR_BIT]) else $error("error flag survived a read");
    ovf_keep_a: assert property (ctl_wr && !BUSY &&
        BUS_REQ.wdata[4:0] != 5'h00 ##1 ctl_rd |=> !BUS_RDATA[CTRL_OVF_BIT])
        else $error("software write changed overflow");

    mul_c: cover property (mul_load ##1 BUSY);
    err_c: cover property (BUSY && op_wr);
    done_c: cover property ($fell(BUSY));
endmodule // mdsu_unit_checker

bind mdsu_unit mdsu_unit_checker #(.MCYCLE_CLOCKS(MCYCLE_CLOCKS)) chk (
    .REF_CLK(REF_CLK), .RESET_N(RESET_N), .CLK_EN(CLK_EN),
    .BUS_REQ(BUS_REQ), .BUS_RDATA(BUS_RDATA), .BUSY(BUSY));

// ---- test/mdsu_cpu_model.sv ----
`timescale 1ns/1ps
// ==========================================================
// cpu core model: one bus strobe per cycle
// ==========================================================
module mdsu_cpu_model
    import mdsu_pkg::*;
(
    input  wire logic           REF_CLK,
    input  wire logic [7:0]     BUS_RDATA,
    output mdsu_pkg::mdsu_bus_t BUS_REQ
);
    initial BUS_REQ = '0;

    // strobe set here, released by whatever call comes next
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge REF_CLK);
        BUS_REQ <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    endtask

    task automatic idle();
        @(posedge REF_CLK);
        BUS_REQ <= '0;
    endtask

    // data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge REF_CLK);
        BUS_REQ <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge REF_CLK);
        BUS_REQ <= '0;
        #1 d = BUS_RDATA;
    endtask

    task automatic load(input int op, input logic [47:0] v,
                        input logic [7:0] ctl);
        int seq[$];
        case (op)
            0: seq = '{0, 1, 2, 3, 4, 5};
            1: seq = '{0, 1, 4, 5};
            2: seq = '{0, 4, 1, 5};
            default: seq = '{0, 1, 2, 3, 6};
        endcase
        foreach (seq[i])
            wr(ADDR_OPERAND_0 + 8'(seq[i]),
               seq[i] == 6 ? ctl : v[8 * seq[i] +: 8]);
    endtask
endmodule // mdsu_cpu_model

// ---- test/mdsu_unit_tb.sv ----
`timescale 1ns/1ps
// ==========================================================
// bench: random operations against a reference model
// ==========================================================
module mdsu_unit_tb;
    import mdsu_pkg::*;
    localparam int MC = 2; // short machine cycle keeps runs brief
    logic        ref_clk  = 1'b0;
    logic        reset_n  = 1'b0;
    mdsu_bus_t   bus_req;
    logic [7:0]  bus_rdata;
    logic        busy;
    int          failures = 0;
    int          checked  = 0;
    int          seed     = 32'hD043;
    int          exp_run;
    logic [47:0] exp_b    = '0;
    logic [7:0]  exp_ctl  = 8'h00;
    logic [47:0] v;
    logic [7:0]  ctl;

    always #5 ref_clk = ~ref_clk;

    mdsu_unit #(.MCYCLE_CLOCKS(MC)) dut (
        .REF_CLK(ref_clk), .RESET_N(reset_n), .CLK_EN(1'b1),
        .BUS_REQ(bus_req), .BUS_RDATA(bus_rdata), .BUSY(busy));
    mdsu_cpu_model cpu (
        .REF_CLK(ref_clk), .BUS_RDATA(bus_rdata), .BUS_REQ(bus_req));

    task automatic conclude();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic cmp(input logic [7:0] got, input logic [7:0] want);
        checked++;
        if (got !== want)
        begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, got, want);
        end
    endtask

    // read one register, compare under a mask
    task automatic rchk(input logic [7:0] a, input logic [7:0] m,
                        input logic [7:0] want);
        logic [7:0] d;
        cpu.rd(a, d);
        cmp(d & m, want);
    endtask

    // model of one operation on v with control byte ctl
    task automatic predict(input int op);
        longint unsigned a;
        longint unsigned b;
        int n;
        exp_b = v;
        b = v[47:32];
        exp_ctl[7:6] = 2'b00;
        if (op >= 3)
            exp_ctl[5:0] = ctl[5:0];
        n = ctl[4:0];
        exp_run = 4 * MC;
        if (op < 2)
        begin
            a = (op == 0) ? v[31:0] : v[15:0];
            exp_run = (op == 0) ? 6 * MC : 4 * MC;
            if (b == 0)
                exp_ctl[6] = 1'b1;
            else if (op == 0)
                exp_b = {16'(a % b), 32'(a / b)};
            else
                exp_b = {16'(a % b), v[31:16], 16'(a / b)};
        end
        else if (op == 2)
        begin
            a = v[15:0] * b;
            exp_b[31:0] = a[31:0];
            exp_ctl[6] = a > 64'hFFFF;
        end
        else
        begin
            if (op == 4)
            begin
                n = 0;
                while (n < 31 && !v[31 - n])
                    n++;
                exp_ctl[4:0] = 5'(n);
                exp_ctl[6] = v[31];
            end
            exp_b[31:0] = (ctl[5] && op == 3) ? v[31:0] >> n : v[31:0] << n;
            exp_run = (n == 0) ? MC : (n + 5) / 6 * MC;
        end
    endtask

    // wait out the run under a bound, then read all back
    task automatic settle(input logic timed);
        int n;
        n = 0;
        #1;
        while (busy === 1'b1 && n < 200)
        begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        if (n >= 200)
        begin
            failures++;
            $display("unexpected at %0t: run did not finish", $time);
            conclude();
        end
        if (timed)
            cmp(8'(n), 8'(exp_run));
        for (int i = 0; i < 7; i++)
            rchk(ADDR_OPERAND_0 + 8'(i), 8'hFF,
                 i == 6 ? exp_ctl : exp_b[8 * i +: 8]);
    endtask

    initial
    begin
        repeat (10) @(posedge ref_clk);
        reset_n <= 1'b1;
        // all registers and one unmapped address read zero
        for (int i = 0; i < 8; i++)
            rchk(8'hE8 + 8'(i), 8'hFF, 8'h00);
        // each kind four times: zero divisors, small products, bit 31
        for (int i = 0; i < 20; i++)
        begin
            v = {$random(seed), $random(seed)};
            ctl = 8'($random(seed));
            if (i < 5)
                v[47:32] = 16'h0000;
            if (i >= 10)
                v = v & 48'h00FF_0000_00FF;
            if (i % 5 == 4)
            begin
                v[31:0] = (v[31:0] >> v[36:32]) | 32'h0000_0001;
                v[31] = (i >= 15);
                ctl[4:0] = 5'h00;
            end
            else if (ctl[4:0] == 5'h00)
                ctl[4:0] = 5'h01;
            // bytes that a load skips keep what the last run left
            if (i % 5 == 1)
                v[31:16] = exp_b[31:16];
            if (i % 5 >= 3)
                v[47:32] = exp_b[47:32];
            predict(i % 5);
            cpu.load(i % 5, v, ctl);
            cpu.idle();
            settle(1'b1);
        end
        // long shift, flag bits written high, operand write while busy
        v = {$random(seed), $random(seed)};
        ctl = 8'hDF;
        v[47:32] = exp_b[47:32];
        predict(3);
        cpu.load(3, v, ctl);
        rchk(ADDR_ARITH_CONTROL, 8'hC0, 8'h00);
        cpu.wr(ADDR_OPERAND_2, 8'hA5);
        rchk(ADDR_ARITH_CONTROL, 8'h80, 8'h80);
        rchk(ADDR_ARITH_CONTROL, 8'h80, 8'h00);
        settle(1'b0);
        // reset in mid-run drops the shift and clears every register
        cpu.load(3, v, 8'h1F);
        cpu.idle();
        @(posedge ref_clk) reset_n <= 1'b0;
        @(posedge ref_clk) reset_n <= 1'b1;
        #1 cmp(8'(busy), 8'h00);
        for (int i = 0; i < 7; i++)
            rchk(ADDR_OPERAND_0 + 8'(i), 8'hFF, 8'h00);
        conclude();
    end
endmodule // mdsu_unit_tb
